// >>> oisr_pkg.sv
package oisr_pkg;

  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int unsigned FRAME_LONG_BITS  = 16;
  localparam int unsigned FRAME_SHORT_BITS = 8;
  localparam int unsigned CHAN_COUNT       = 8;
  localparam int unsigned CRC_BITS         = 5;
  localparam logic [4:0]  CRC_POLY         = 5'h15;   // x^4 + x^2 + 1 (x^5 implied)
  localparam logic [4:0]  CRC_SEED         = 5'h00;
  localparam logic        STOP_BIT_VALUE   = 1'b1;
  localparam logic        WIDTH_SEL_LONG   = 1'b0;

  // ----------------------------------------
  // Snapshot FIFO
  // ----------------------------------------
  localparam int unsigned SNAP_FIFO_DEPTH  = 8;

  // ----------------------------------------
  // Link timing (bench link clock period)
  // ----------------------------------------
  localparam int unsigned SYS_CLK_PERIOD_NS  = 25;
  localparam int unsigned LINK_CLK_PERIOD_NS = 200;
  localparam int unsigned LINK_HALF_CYCLES   = LINK_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);

  typedef struct packed {
    logic [7:0] chan;
    logic       supply_low;
    logic       overtemp;
  } oisr_snap_s;

  localparam int unsigned SNAP_WIDTH = $bits(oisr_snap_s);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT
  } oisr_state_e;

endpackage : oisr_pkg

// >>> oisr_fifo.sv
`timescale 1ns/10ps
module oisr_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [WIDTH-1:0] out_data_q;
  logic             out_valid_q;

  wire        push      = in_valid_i && in_ready_o;
  wire        stored    = count_q != '0;
  wire        take_out  = out_valid_q && out_ready_i;
  wire        refill    = stored && (!out_valid_q || take_out);

  assign in_ready_o  = count_q != (AW+1)'(DEPTH);
  assign out_valid_o = out_valid_q;
  assign out_data_o  = out_data_q;

  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_ptr_q    <= '0;
      rd_ptr_q    <= '0;
      count_q     <= '0;
      out_valid_q <= 1'b0;
      out_data_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (refill) begin
        rd_ptr_q   <= rd_ptr_q + AW'(1);
        out_data_q <= mem_q[rd_ptr_q];
      end
      count_q     <= count_q + (AW+1)'(push) - (AW+1)'(refill);
      out_valid_q <= refill || (out_valid_q && !take_out);
    end
  end

endmodule : oisr_fifo

// >>> oisr_serial_readout.sv
// Overview of operation
// [R1] Width select low: frame carries inputs, five CRC bits, supply and thermal flags.
// [R2] Width select high: only the eight input states are sent.
// [R3] Long frame order: input 8..1, CRC, supply flag, thermal flag, stop.
// [R4] Serial output of each device feeds chain input of the next.
// [R5] All chained devices share chip select and serial clock.
// [R6] Mode 0: clock idles low, master samples on rising edges.
// [R7] Input states captured into shift register as chip select falls.
// [R8] First frame bit drives output right after chip select asserts.
// [R9] Output advances one bit per falling serial clock edge.
// [R10] Frame shifted most significant bit first.
// [R11] Output released while chip select is high.
// [R12] Master ignores bits after input 1 in short mode unless chained.
// [R13] CRC generator polynomial is x^5 + x^4 + x^2 + 1.
// [R14] Last bit of the long frame is always one.
// [R15] Supply flag follows the field supply monitor level.
// [R16] Thermal flag follows the junction temperature alarm level.
// [R17] Chain input enters the shift register low end on each shift; short frames take it at bit 8 instead of bit 0.
// [R18] Master holds chip select for width times device count clocks.
`timescale 1ns/10ps
module oisr_serial_readout
  import oisr_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] field_input_channels_i,
  input  wire logic       field_supply_low_i,
  input  wire logic       overtemp_alarm_i,
  input  wire logic       frame_width_select_i,
  input  wire logic       chip_select_b_i,
  input  wire logic       serial_clk_i,
  input  wire logic       chain_data_input_i,
  output logic            serial_data_output_o,
  output logic            serial_data_output_oe_b_o,
  output logic            frame_active_o,
  output logic            snap_overflow_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] cs_sync_q;
  logic [2:0] sck_sync_q;
  logic [1:0] sin_sync_q;
  logic [1:0] sel_sync_q;
  logic [7:0] chan_meta_q;
  logic [7:0] chan_sync_q;
  logic [1:0] supply_sync_q;
  logic [1:0] temp_sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cs_sync_q     <= 3'h7;
      sck_sync_q    <= 3'h0;
      sin_sync_q    <= 2'h0;
      sel_sync_q    <= 2'h0;
      chan_meta_q   <= 8'h00;
      chan_sync_q   <= 8'h00;
      supply_sync_q <= 2'h0;
      temp_sync_q   <= 2'h0;
    end else begin
      cs_sync_q     <= {cs_sync_q[1:0], chip_select_b_i};
      sck_sync_q    <= {sck_sync_q[1:0], serial_clk_i};
      sin_sync_q    <= {sin_sync_q[0], chain_data_input_i};
      sel_sync_q    <= {sel_sync_q[0], frame_width_select_i};
      chan_meta_q   <= field_input_channels_i;
      chan_sync_q   <= chan_meta_q;
      supply_sync_q <= {supply_sync_q[0], field_supply_low_i};
      temp_sync_q   <= {temp_sync_q[0], overtemp_alarm_i};
    end
  end

  // Edge detection only on the second and third stages
  wire cs_low    = !cs_sync_q[1];
  wire cs_fall   = cs_sync_q[2] && !cs_sync_q[1];
  wire sck_fall  = sck_sync_q[2] && !sck_sync_q[1];
  wire sin_bit   = sin_sync_q[1];
  wire long_mode = sel_sync_q[1] == WIDTH_SEL_LONG;

  // ----------------------------------------
  // Snapshot capture and FIFO
  // ----------------------------------------
  oisr_snap_s snap_in;
  oisr_snap_s snap_out;
  logic       snap_in_ready;
  logic       snap_out_valid;
  logic       snap_take;

  assign snap_in.chan       = chan_sync_q;
  assign snap_in.supply_low = supply_sync_q[1];   // R15
  assign snap_in.overtemp   = temp_sync_q[1];     // R16

  oisr_fifo #(
    .WIDTH (SNAP_WIDTH),
    .DEPTH (SNAP_FIFO_DEPTH)
  ) u_snap_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (cs_fall),                        // R7
    .in_ready_o  (snap_in_ready),
    .in_data_i   (snap_in),
    .out_valid_o (snap_out_valid),
    .out_ready_i (snap_take),
    .out_data_o  (snap_out)
  );

  // ----------------------------------------
  // CRC over the eight input states
  // ----------------------------------------
  function automatic logic [4:0] crc5_calc(input logic [7:0] data);
    logic [4:0] crc;
    logic       fb;
    crc = CRC_SEED;
    for (int i = 7; i >= 0; i--) begin
      fb  = crc[4] ^ data[i];
      crc = {crc[3:0], 1'b0} ^ (fb ? CRC_POLY : 5'h00);   // R13
    end
    return crc;
  endfunction : crc5_calc

  wire [4:0]  snap_crc   = crc5_calc(snap_out.chan);
  wire [15:0] frame_long = {snap_out.chan, snap_crc, snap_out.supply_low,
                            snap_out.overtemp, STOP_BIT_VALUE};      // R1 R3 R14
  wire [15:0] frame_short = {snap_out.chan, 8'h00};                  // R2

  // ----------------------------------------
  // Frame state machine and shift register
  // ----------------------------------------
  oisr_state_e state_q;
  oisr_state_e state_d;
  logic [15:0] shift_q;
  logic        overflow_q;

  // Stale snapshots left by a runt select are dropped while idle
  assign snap_take = (state_q != ST_SHIFT) && snap_out_valid;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (cs_low) begin
        state_d = ST_LOAD;
      end
      ST_LOAD:  if (!cs_low) begin
        state_d = ST_IDLE;
      end else if (snap_out_valid) begin
        state_d = ST_SHIFT;
      end
      ST_SHIFT: if (!cs_low) begin
        state_d = ST_IDLE;
      end
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Short frames take the chain bit at bit 8 so it follows input 1
  wire        shift_step  = (state_q == ST_SHIFT) && sck_fall;
  wire [15:0] shift_long  = {shift_q[14:0], sin_bit};              // R9 R10 R17
  wire [15:0] shift_short = {shift_q[14:8], sin_bit, 8'h00};       // R9 R10 R17
  wire [15:0] frame_sel   = long_mode ? frame_long : frame_short;  // R1 R2
  wire [15:0] step_sel    = long_mode ? shift_long : shift_short;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      shift_q <= 16'h0000;
    end else if (snap_take) begin
      shift_q <= frame_sel;
    end else if (shift_step) begin
      shift_q <= step_sel;
    end
  end

  // Shifts since the last load, used by the checks only
  logic [4:0] shift_cnt_q;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i || snap_take) begin
      shift_cnt_q <= 5'h00;
    end else if (shift_step && shift_cnt_q != 5'h1f) begin
      shift_cnt_q <= shift_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      overflow_q <= 1'b0;
    end else if (cs_fall && !snap_in_ready) begin
      overflow_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Output enable is low only while a frame is shifting
  assign serial_data_output_o      = shift_q[15];             // R8 R10 R6
  assign serial_data_output_oe_b_o = state_q != ST_SHIFT;     // R11
  assign frame_active_o            = state_q == ST_SHIFT;
  assign snap_overflow_o           = overflow_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Codeword remainder: zero when the CRC field divides cleanly
  function automatic logic [4:0] crc5_residue(input logic [12:0] cw);
    logic [4:0] rem;
    logic       top;
    rem = 5'h00;
    for (int i = 12; i >= 0; i--) begin
      top = rem[4];
      rem = {rem[3:0], cw[i]} ^ (top ? CRC_POLY : 5'h00);
    end
    return rem;
  endfunction : crc5_residue

  frame_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R14
    snap_take && long_mode |=> shift_q[0] == STOP_BIT_VALUE)
    else $error("stop bit not loaded");

  short_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R2
    snap_take && !long_mode |=> shift_q[7:0] == 8'h00)
    else $error("short frame carries status bits");

  msb_first_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R10
    snap_take |=> serial_data_output_o == $past(snap_out.chan[7]))
    else $error("first bit is not input 8");

  chan_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R7
    snap_take |=> shift_q[15:8] == $past(snap_out.chan))
    else $error("input states not loaded");

  crc_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R13
    snap_take && long_mode |=> crc5_residue(shift_q[15:3]) == 5'h00)
    else $error("crc field wrong");

  flags_load_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R15 R16
    snap_take && long_mode |=> shift_q[2:1] == $past({snap_out.supply_low, snap_out.overtemp}))
    else $error("alarm flags wrong");

  release_hi_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R11
    !cs_low |=> serial_data_output_oe_b_o)
    else $error("output driven with select high");

  reset_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R11
    $rose(rst_b_i) |-> serial_data_output_oe_b_o && !frame_active_o && !snap_overflow_o)
    else $error("outputs not idle after reset");

  first_bit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R8
    cs_fall |-> ##[1:3] !serial_data_output_oe_b_o || !cs_low)
    else $error("first bit late after select");

  shift_start_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R8
    $rose(frame_active_o) |-> $past(snap_take))
    else $error("frame started without a fresh load");

  // ----------------------------------------
  // Checks: shifting
  // ----------------------------------------

  shift_step_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R9
    state_q == ST_SHIFT && state_d == ST_SHIFT && sck_fall && long_mode && !snap_take
    |=> shift_q == {$past(shift_q[14:0]), $past(sin_bit)})
    else $error("shift step wrong");

  short_shift_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R9 R17
    shift_step && !long_mode && !snap_take |=> shift_q[15:8] == {$past(shift_q[14:8]), $past(sin_bit)})
    else $error("short shift step wrong");

  shift_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R9
    !snap_take && !shift_step |=> $stable(shift_q))
    else $error("shift register moved without link clock");

  chain_in_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R17
    shift_step && !snap_take |=> ($past(long_mode) ? shift_q[0] : shift_q[8]) == $past(sin_bit))
    else $error("chain bit not taken");

  stop_pos_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // R3 R14
    frame_active_o && long_mode && shift_cnt_q == 5'(FRAME_LONG_BITS - 1) |-> serial_data_output_o == STOP_BIT_VALUE)
    else $error("stop bit not in last place");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------

  cover_long_c:  cover property (@(posedge sys_clk_i) snap_take && long_mode);
  cover_short_c: cover property (@(posedge sys_clk_i) snap_take && !long_mode);
  cover_shift_c: cover property (@(posedge sys_clk_i) frame_active_o && sck_fall);
  cover_chain_c: cover property (@(posedge sys_clk_i) shift_step && sin_bit);
  cover_runt_c:  cover property (@(posedge sys_clk_i) snap_take && state_q == ST_IDLE);

endmodule : oisr_serial_readout

// >>> oisr_spi_master.sv
`timescale 1ns/10ps
module oisr_spi_master (
  output logic      chip_select_b_o,
  output logic      serial_clk_o,
  input  wire logic serial_data_i
);
  localparam int HALF_NS = 100;
  localparam int SYS_NS  = 25;

  initial begin
    chip_select_b_o = 1'b1;
    serial_clk_o    = 1'b0;
  end

  // ----------------------------------------
  // Frame read: sample on rise, device shifts on fall
  // ----------------------------------------
  task automatic xfer(input int nbits, input int lead_ns, output logic [31:0] bits);
    bits = '0;
    chip_select_b_o = 1'b0;
    #(lead_ns);
    for (int i = 0; i < nbits; i++) begin
      bits = {bits[30:0], serial_data_i};
      serial_clk_o = 1'b1;
      #(HALF_NS);
      serial_clk_o = 1'b0;
      #(HALF_NS);
    end
    chip_select_b_o = 1'b1;
    #(4 * HALF_NS);
  endtask : xfer

  // Runt select: low for one system clock, no link clock
  task automatic cs_blip();
    chip_select_b_o = 1'b0;
    #(SYS_NS);
    chip_select_b_o = 1'b1;
    #(2 * HALF_NS);
  endtask : cs_blip
endmodule : oisr_spi_master

// >>> octal_input_serial_readout_tb_top.sv
`timescale 1ns/10ps
module octal_input_serial_readout_tb_top;
  import oisr_pkg::*;
  logic       sys_clk, rst_b, supply_low, overtemp, width_sel, chain_in;
  logic [7:0] chan;
  logic       cs_b, sclk, sdo, sdo_oe_b, frame_active, overflow;
  wire        sdo_wire = sdo_oe_b ? 1'bz : sdo;
  int         err_total = 0;
  int         num_checks = 0;

  oisr_serial_readout u_oisr_serial_readout (
    .sys_clk_i                 (sys_clk),
    .rst_b_i                   (rst_b),
    .field_input_channels_i    (chan),
    .field_supply_low_i        (supply_low),
    .overtemp_alarm_i          (overtemp),
    .frame_width_select_i      (width_sel),
    .chip_select_b_i           (cs_b),
    .serial_clk_i              (sclk),
    .chain_data_input_i        (chain_in),
    .serial_data_output_o      (sdo),
    .serial_data_output_oe_b_o (sdo_oe_b),
    .frame_active_o            (frame_active),
    .snap_overflow_o           (overflow)
  );

  oisr_spi_master u_oisr_spi_master (
    .chip_select_b_o (cs_b),
    .serial_clk_o    (sclk),
    .serial_data_i   (sdo_wire)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Compare and report
  // ----------------------------------------
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  task automatic check_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit

  task automatic check_frame(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH frame expected %h seen %h", exp, got);
    end
  endtask : check_frame

  function automatic logic [4:0] crc5_ref(input logic [7:0] d);
    logic [4:0] c;
    logic       fb;
    c = CRC_SEED;
    for (int i = 7; i >= 0; i--) begin
      fb = c[4] ^ d[i];
      c  = {c[3:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c;
  endfunction : crc5_ref

  // ----------------------------------------
  // One framed read with expectation
  // ----------------------------------------
  task automatic run_frame(input logic [7:0] ch, input logic uv, input logic ot, input logic ws, input logic cin);
    logic [31:0] exp;
    logic [31:0] got;
    int          nb;
    @(posedge sys_clk);
    #2;
    chan       = ch;
    supply_low = uv;
    overtemp   = ot;
    width_sel  = ws;
    chain_in   = cin;
    repeat (4) @(posedge sys_clk);
    #2;
    check_bit("oe_b idle", 1'b1, sdo_oe_b);
    if (ws == WIDTH_SEL_LONG) begin
      nb  = 20;
      exp = {12'h000, ch, crc5_ref(ch), uv, ot, STOP_BIT_VALUE, {4{cin}}};
    end else begin
      nb  = 12;
      exp = {20'h0_0000, ch, {4{cin}}};
    end
    fork
      u_oisr_spi_master.xfer(nb, 400, got);
      begin
        repeat (12) @(posedge sys_clk);
        #2;
        check_bit("oe_b first", 1'b0, sdo_oe_b);
        check_bit("first bit", ch[7], sdo_wire);
        chan = ~ch;
      end
    join
    check_frame(exp, got);
    check_bit("oe_b after", 1'b1, sdo_oe_b);
    check_bit("active after", 1'b0, frame_active);
  endtask : run_frame

  initial begin
    #200_000;
    err_total++;
    report_and_stop();
  end

  initial begin
    rst_b      = 1'b0;
    chan       = 8'h00;
    supply_low = 1'b0;
    overtemp   = 1'b0;
    width_sel  = WIDTH_SEL_LONG;
    chain_in   = 1'b0;
    repeat (4) @(posedge sys_clk);
    #2;
    rst_b = 1'b1;
    repeat (3) @(posedge sys_clk);
    run_frame(8'hA5, 1'b0, 1'b0, 1'b0, 1'b0);
    run_frame(8'h3C, 1'b1, 1'b0, 1'b0, 1'b1);
    run_frame(8'h81, 1'b0, 1'b1, 1'b0, 1'b0);
    run_frame(8'hFF, 1'b1, 1'b1, 1'b0, 1'b1);
    run_frame(8'h00, 1'b0, 1'b0, 1'b0, 1'b1);
    run_frame(8'h5A, 1'b1, 1'b1, 1'b1, 1'b1);
    run_frame(8'hC3, 1'b0, 1'b0, 1'b1, 1'b0);
    chan = 8'h66;
    repeat (4) @(posedge sys_clk);
    #2;
    u_oisr_spi_master.cs_blip();
    run_frame(8'h99, 1'b0, 1'b1, 1'b0, 1'b0);
    check_bit("overflow", 1'b0, overflow);
    report_and_stop();
  end
endmodule : octal_input_serial_readout_tb_top
